// ---- src/agc_pkg.sv ----
// Package with register map, field layout and reset values of the bank.
package agc_pkg;
	// Printed offsets are word indices; byte address is four times each.
	localparam logic [3:0]  GAIN_IDX       = 4'h4;
	localparam logic [3:0]  RSVD_IDX       = 4'h5;
	localparam logic [3:0]  CFG_IDX        = 4'h6;
	localparam logic [3:0]  THR_IDX        = 4'h7;
	localparam logic [3:0]  IRQ_STAT_IDX   = 4'h8;
	localparam logic [3:0]  IRQ_MASK_IDX   = 4'h9;
	localparam logic [15:0] GAIN_RST       = 16'h0000;
	localparam logic [15:0] RSVD_RST       = 16'h0000;
	localparam logic [15:0] CFG_RST        = 16'h0600;
	localparam logic [15:0] THR_RST        = 16'h0000;
	localparam logic [15:0] GAIN_RW_MASK   = 16'h0777;
	localparam logic [15:0] CFG_RW_MASK    = 16'h1fff;
	localparam int          CH2_GAIN_LSB   = 8;
	localparam int          CH1_GAIN_LSB   = 4;
	localparam int          CH0_GAIN_LSB   = 0;
	localparam int          DLY_LSB        = 9;
	localparam int          CHOP_EN_BIT    = 8;
	localparam int          ALLCH_BIT      = 7;
	localparam int          NUM_LSB        = 4;
	localparam int          LEN_LSB        = 1;
	localparam int          DET_EN_BIT     = 0;
	localparam int          NUM_EVENTS     = 4;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	typedef enum logic [0:0]
	{
		AGC_IDLE = 1'b0,
		AGC_DATA = 1'b1
	} agc_phase_e;
endpackage

// ---- src/agc_decode.sv ----
// Decoder of configuration codes into gain, delay and length figures.
`timescale 1ns/100ps
module agc_decode
	import agc_pkg::*;
(
	input  wire logic [15:0] i_gain,
	input  wire logic [15:0] i_cfg,
	output logic      [7:0]  o_ch0_gain,
	output logic      [7:0]  o_ch1_gain,
	output logic      [7:0]  o_ch2_gain,
	output logic      [16:0] o_settle_periods,
	output logic      [7:0]  o_exceed_needed,
	output logic      [11:0] o_window_periods
);
	function automatic logic [7:0] pow2_8(input logic [2:0] code);
		pow2_8 = 8'h01 << code;
	endfunction

	function automatic logic [11:0] window_len(input logic [2:0] code);
		case (code)
			3'h0: window_len = 12'h080;
			3'h1: window_len = 12'h100;
			3'h2: window_len = 12'h200;
			3'h3: window_len = 12'h300;
			3'h4: window_len = 12'h500;
			3'h5: window_len = 12'h700;
			3'h6: window_len = 12'ha00;
			default: window_len = 12'he00;
		endcase
	endfunction

	always_comb
	begin
		o_ch2_gain = pow2_8(i_gain[CH2_GAIN_LSB +: 3]);
		o_ch1_gain = pow2_8(i_gain[CH1_GAIN_LSB +: 3]);
		o_ch0_gain = pow2_8(i_gain[CH0_GAIN_LSB +: 3]);
		o_settle_periods = 17'h00002 << i_cfg[DLY_LSB +: 4];
		o_exceed_needed = pow2_8(i_cfg[NUM_LSB +: 3]);
		o_window_periods = window_len(i_cfg[LEN_LSB +: 3]);
	end
endmodule // agc_decode

// ---- src/agc_regs.sv ----
// AHB-Lite register bank for converter gain, chop and detect settings.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
module agc_regs
	import agc_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic      [2:0]  o_ch0_gain_code,
	output logic      [2:0]  o_ch1_gain_code,
	output logic      [2:0]  o_ch2_gain_code,
	output logic      [7:0]  o_ch0_gain,
	output logic      [7:0]  o_ch1_gain,
	output logic      [7:0]  o_ch2_gain,
	output logic      [3:0]  o_chop_settle_delay,
	output logic      [16:0] o_settle_periods,
	output logic             o_chop_enable,
	output logic             o_detect_all_channels,
	output logic      [2:0]  o_detect_exceed_count,
	output logic      [7:0]  o_exceed_needed,
	output logic      [2:0]  o_detect_window_length,
	output logic      [11:0] o_window_periods,
	output logic             o_detect_mode_enable,
	output logic      [15:0] o_detect_threshold_high,
	output logic             o_irq
);
	// Status bits: 0 gain written, 1 config written, 2 threshold written,
	// 3 nonzero data written to the reserved word.
	logic             wr_pend_q;
	logic             wr_pend_d;
	logic      [3:0]  wr_idx_q;
	logic      [3:0]  wr_idx_d;
	logic      [15:0] gain_q;
	logic      [15:0] gain_d;
	logic      [15:0] rsvd_q;
	logic      [15:0] rsvd_d;
	logic      [15:0] cfg_q;
	logic      [15:0] cfg_d;
	logic      [15:0] thr_q;
	logic      [15:0] thr_d;
	logic      [NUM_EVENTS-1:0] stat_q;
	logic      [NUM_EVENTS-1:0] stat_d;
	logic      [NUM_EVENTS-1:0] mask_q;
	logic      [NUM_EVENTS-1:0] mask_d;
	logic      [31:0] rdata_q;
	logic      [31:0] rdata_d;
	logic             irq_q;
	logic             irq_d;
	logic      [7:0]  g0_q;
	logic      [7:0]  g1_q;
	logic      [7:0]  g2_q;
	logic      [16:0] settle_q;
	logic      [7:0]  exceed_q;
	logic      [11:0] win_q;
	logic      [7:0]  g0_w;
	logic      [7:0]  g1_w;
	logic      [7:0]  g2_w;
	logic      [16:0] settle_w;
	logic      [7:0]  exceed_w;
	logic      [11:0] win_w;
	logic             acc;
	logic      [3:0]  a_idx;
	logic      [NUM_EVENTS-1:0] ev;
	logic      [15:0] wd;

	agc_decode u_decode
	(
		.i_gain           (gain_q),
		.i_cfg            (cfg_q),
		.o_ch0_gain       (g0_w),
		.o_ch1_gain       (g1_w),
		.o_ch2_gain       (g2_w),
		.o_settle_periods (settle_w),
		.o_exceed_needed  (exceed_w),
		.o_window_periods (win_w)
	);

	always_comb
	begin
		acc = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
		a_idx = i_haddr[5:2];
		wd = i_hwdata[15:0];
		wr_pend_d = acc && i_hwrite;
		wr_idx_d = acc ? a_idx : wr_idx_q;
		gain_d = gain_q;
		rsvd_d = rsvd_q;
		cfg_d = cfg_q;
		thr_d = thr_q;
		mask_d = mask_q;
		ev = '0;
		if (wr_pend_q)
		begin
			if (wr_idx_q == GAIN_IDX)
			begin
				// Reserved bits are held at zero in case software slips.
				gain_d = wd & GAIN_RW_MASK;
				ev[0] = 1'b1;
			end
			else if (wr_idx_q == RSVD_IDX)
			begin
				rsvd_d = wd;
				ev[3] = (wd != 16'h0000);
			end
			else if (wr_idx_q == CFG_IDX)
			begin
				cfg_d = wd & CFG_RW_MASK;
				ev[1] = 1'b1;
			end
			else if (wr_idx_q == THR_IDX)
			begin
				thr_d = wd;
				ev[2] = 1'b1;
			end
			else if (wr_idx_q == IRQ_MASK_IDX)
			begin
				mask_d = wd[NUM_EVENTS-1:0];
			end
		end
		rdata_d = 32'h00000000;
		stat_d = stat_q;
		if (acc && !i_hwrite)
		begin
			if (a_idx == GAIN_IDX)
				rdata_d = {16'h0000, gain_q};
			else if (a_idx == RSVD_IDX)
				rdata_d = {16'h0000, rsvd_q};
			else if (a_idx == CFG_IDX)
				rdata_d = {16'h0000, cfg_q};
			else if (a_idx == THR_IDX)
				rdata_d = {16'h0000, thr_q};
			else if (a_idx == IRQ_STAT_IDX)
			begin
				rdata_d = {28'h0000000, stat_q};
				stat_d = '0;
			end
			else if (a_idx == IRQ_MASK_IDX)
				rdata_d = {28'h0000000, mask_q};
			else
				rdata_d = 32'h00000000;
		end
		else if (!acc)
			rdata_d = rdata_q;
		// A new event in the clearing cycle survives the read.
		stat_d = stat_d | ev;
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 4'h0;
			gain_q    <= GAIN_RST;
			rsvd_q    <= RSVD_RST;
			cfg_q     <= CFG_RST;
			thr_q     <= THR_RST;
			stat_q    <= '0;
			mask_q    <= '0;
			rdata_q   <= 32'h00000000;
			irq_q     <= 1'b0;
			g0_q      <= 8'h01;
			g1_q      <= 8'h01;
			g2_q      <= 8'h01;
			settle_q  <= 17'h00010;
			exceed_q  <= 8'h01;
			win_q     <= 12'h080;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			wr_idx_q  <= wr_idx_d;
			gain_q    <= gain_d;
			rsvd_q    <= rsvd_d;
			cfg_q     <= cfg_d;
			thr_q     <= thr_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			rdata_q   <= rdata_d;
			irq_q     <= irq_d;
			// Decoded figures lag the code by one cycle.
			g0_q      <= g0_w;
			g1_q      <= g1_w;
			g2_q      <= g2_w;
			settle_q  <= settle_w;
			exceed_q  <= exceed_w;
			win_q     <= win_w;
		end
	end

	assign o_hrdata = rdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_ch0_gain_code = gain_q[CH0_GAIN_LSB +: 3];
	assign o_ch1_gain_code = gain_q[CH1_GAIN_LSB +: 3];
	assign o_ch2_gain_code = gain_q[CH2_GAIN_LSB +: 3];
	assign o_ch0_gain = g0_q;
	assign o_ch1_gain = g1_q;
	assign o_ch2_gain = g2_q;
	assign o_chop_settle_delay = cfg_q[DLY_LSB +: 4];
	assign o_settle_periods = settle_q;
	assign o_chop_enable = cfg_q[CHOP_EN_BIT];
	assign o_detect_all_channels = cfg_q[ALLCH_BIT];
	assign o_detect_exceed_count = cfg_q[NUM_LSB +: 3];
	assign o_exceed_needed = exceed_q;
	assign o_detect_window_length = cfg_q[LEN_LSB +: 3];
	assign o_window_periods = win_q;
	assign o_detect_mode_enable = cfg_q[DET_EN_BIT];
	assign o_detect_threshold_high = thr_q;
	assign o_irq = irq_q;
endmodule // agc_regs

// ---- tb/agc_regs_chk.sv ----
// Checker of decoded figures and register updates of the bank.
`timescale 1ns/100ps
module agc_regs_chk
	import agc_pkg::*;
(
	input wire logic	i_mclk,
	input wire logic	i_rst_n,
	input wire logic	i_hsel,
	input wire logic [31:0]	i_haddr,
	input wire logic [1:0]	i_htrans,
	input wire logic	i_hwrite,
	input wire logic [31:0]	i_hwdata,
	input wire logic	i_hready,
	input wire logic [31:0]	o_hrdata,
	input wire logic	o_hreadyout,
	input wire logic	o_hresp,
	input wire logic [2:0]	o_ch0_gain_code,
	input wire logic [2:0]	o_ch1_gain_code,
	input wire logic [2:0]	o_ch2_gain_code,
	input wire logic [7:0]	o_ch0_gain,
	input wire logic [7:0]	o_ch1_gain,
	input wire logic [7:0]	o_ch2_gain,
	input wire logic [3:0]	o_chop_settle_delay,
	input wire logic [16:0]	o_settle_periods,
	input wire logic	o_chop_enable,
	input wire logic	o_detect_all_channels,
	input wire logic [2:0]	o_detect_exceed_count,
	input wire logic [7:0]	o_exceed_needed,
	input wire logic [2:0]	o_detect_window_length,
	input wire logic [11:0]	o_window_periods,
	input wire logic	o_detect_mode_enable,
	input wire logic [15:0]	o_detect_threshold_high,
	input wire logic	o_irq
);
	localparam logic [11:0] WIN [8] = '{12'd128, 12'd256, 12'd512, 12'd768,
		12'd1280, 12'd1792, 12'd2560, 12'd3584};
	logic		acc;
	logic [15:0]	g;
	logic [15:0]	c;
	assign acc = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
	assign g = {5'h0, o_ch2_gain_code, 1'b0, o_ch1_gain_code, 1'b0,
		o_ch0_gain_code};
	assign c = {3'h0, o_chop_settle_delay, o_chop_enable,
		o_detect_all_channels, o_detect_exceed_count,
		o_detect_window_length, o_detect_mode_enable};
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	AST_GAIN2: assert property (o_ch2_gain == 8'h1 << $past(o_ch2_gain_code))
		else $error("ch2 gain figure wrong");
	AST_CHANNEL_GAIN_SELECT: assert property (o_ch1_gain == 8'h1 << $past(o_ch1_gain_code))
		else $error("ch1 gain figure wrong");
	AST_BUS_OK: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready or not okay");
	AST_GAIN0: assert property (o_ch0_gain == 8'h1 << $past(o_ch0_gain_code))
		else $error("ch0 gain figure wrong");
	AST_SETTLE: assert property (o_settle_periods == 17'h2 << $past(o_chop_settle_delay))
		else $error("settle figure wrong");
	AST_EXCEED: assert property (o_exceed_needed == 8'h1 << $past(o_detect_exceed_count))
		else $error("exceed figure wrong");
	AST_WINDOW: assert property (o_window_periods == WIN[$past(o_detect_window_length)])
		else $error("window figure wrong");
	AST_GAIN_WR: assert property (acc && i_hwrite && i_haddr == 32'h10 ##1 1'b1 |=> g == ($past(i_hwdata[15:0]) & 16'h0777))
		else $error("gain write not taken");
	AST_CFG_WR: assert property (acc && i_hwrite && i_haddr == 32'h18 ##1 1'b1 |=> c == ($past(i_hwdata[15:0]) & 16'h1fff))
		else $error("config write not taken");
	AST_THR_WR: assert property (acc && i_hwrite && i_haddr == 32'h1c ##1 1'b1 |=> o_detect_threshold_high == $past(i_hwdata[15:0]))
		else $error("threshold write not taken");
	AST_CFG_RD: assert property (acc && !i_hwrite && i_haddr == 32'h18 |=> o_hrdata == {16'h0, $past(c)})
		else $error("config read wrong");
	cover property (acc && i_hwrite && i_haddr == 32'h18);
	cover property ($rose(o_irq));
	cover property (o_settle_periods == 17'h10000);
endmodule // agc_regs_chk

bind agc_regs agc_regs_chk u_chk (.*);

// ---- tb/tb_top.sv ----
// Self-checking bench for the gain, chop and detect register bank.
`timescale 1ns/100ps
module tb_top
	import agc_pkg::*;
;
	logic		i_mclk, i_rst_n, i_hsel, i_hwrite, o_hreadyout, o_irq, ph;
	logic [31:0]	i_haddr, i_hwdata, o_hrdata, s;
	logic [1:0]	i_htrans;
	logic [2:0]	i_hsize;
	logic [31:0]	q [$];
	int		err_count = 0;
	int		num_checks = 0;
	agc_regs DUT (.i_mclk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
		.i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout,
		.o_hresp(), .o_ch0_gain_code(), .o_ch1_gain_code(), .o_ch2_gain_code(),
		.o_ch0_gain(), .o_ch1_gain(), .o_ch2_gain(), .o_chop_settle_delay(),
		.o_settle_periods(), .o_chop_enable(), .o_detect_all_channels(),
		.o_detect_exceed_count(), .o_exceed_needed(), .o_window_periods(),
		.o_detect_window_length(), .o_detect_mode_enable(),
		.o_detect_threshold_high(), .o_irq);
	task automatic print_verdict();
		$display("errors %0d checks %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Every wait is bounded so a stuck slave ends the run instead of hanging.
	task automatic wt();
		for (int n = 0; n < 99; n++)
		begin
			@(posedge i_mclk);
			if (o_hreadyout === 1'b1)
				return;
		end
		err_count++;
		print_verdict();
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_htrans <= HTRANS_NONSEQ;
		i_haddr <= a;
		i_hwrite <= w;
		wt();
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		wt();
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	always @(posedge i_mclk)
	begin
		if (ph === 1'b1)
			chk(o_hrdata, q.pop_front());
		ph <= i_rst_n && i_hsel && i_htrans == HTRANS_NONSEQ && !i_hwrite;
	end
	initial
	begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	initial
	begin
		{i_rst_n, i_hsel, i_hwrite, i_htrans, i_haddr, i_hwdata} = '0;
		i_hsize = 3'h2;
		s = 32'h5b665c87;
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		rd(32'h10, 32'h0);
		rd(32'h14, 32'h0);
		rd(32'h18, 32'h600);
		rd(32'h1c, 32'h0);
		rd(32'h24, 32'h0);
		rd(32'h30, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			s = lfsr(s);
			xfer(1'b1, 32'h10, s);
			xfer(1'b1, 32'h18, ~s);
			xfer(1'b1, 32'h1c, s);
			rd(32'h1c, {16'h0, s[15:0]});
			rd(32'h18, ~s & 32'h1fff);
			rd(32'h10, s & 32'h777);
		end
		xfer(1'b1, 32'h14, 32'h0);
		chk({31'h0, o_irq}, 32'h0);
		rd(32'h20, 32'h7);
		rd(32'h20, 32'h0);
		xfer(1'b1, 32'h24, 32'hf);
		xfer(1'b1, 32'h14, 32'h1);
		rd(32'h14, 32'h1);
		#1 chk({31'h0, o_irq}, 32'h1);
		@(posedge i_mclk);
		rd(32'h20, 32'h8);
		repeat (2) @(posedge i_mclk);
		#1 chk({31'h0, o_irq}, 32'h0);
		print_verdict();
	end
endmodule // tb_top
